// file: core/ean13_defs.svh
// Constants for the EAN-13 add-on filter and formatter
`ifndef EAN13_DEFS_SVH
`define EAN13_DEFS_SVH
`define CLK_PERIOD_NS 32'h0000_0028
`define MS_PERIOD_NS  32'h000F_4240
`define MS_CYCLES     (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define TMO_DEF       16'h0064
`define RED_DEF       4'h0
`define RED_MAX       4'hA
`define ASC_ZERO_HI   4'h3
`define ASC_SPACE     8'h20
`define ASC_HYPHEN    8'h2D
`define ASC_X         8'h58
`define PFX_290       12'h290
`define PFX_378       12'h378
`define PFX_379       12'h379
`define PFX_414       12'h414
`define PFX_419       12'h419
`define PFX_434       12'h434
`define PFX_439       12'h439
`define PFX_977       12'h977
`define PFX_978       12'h978
`define PFX_979       12'h979
`define LEAD_TWO      4'h2
`endif

// file: core/ean13_pkg.sv
// Types for the EAN-13 add-on filter and formatter
package ean13_pkg;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_EMIT} state_t;
  typedef enum logic [1:0] {M_NONE, M_FIVE, M_TWO, M_ANY} amode_t;
  typedef struct packed {
    logic        req2;
    logic        req290;
    logic        req977;
    logic        req978;
    logic        req979;
    amode_t      mode378;
    amode_t      mode414;
    amode_t      mode434;
    logic        addon_req;
    logic [15:0] tmo;
    logic        sep;
    logic [3:0]  redund;
    logic        isbn_en;
    logic        isbn13;
    logic        isbn_refmt;
    logic        issn_en;
    logic        issn_refmt;
  } cfg_t;
  typedef struct packed {
    logic [19:0][7:0] ch;
    logic [4:0]       len;
  } line_t;
  typedef struct packed {
    state_t      st;
    cfg_t        cfg;
    logic [51:0] sym;
    logic [51:0] last;
    logic [3:0]  votes;
    logic [15:0] ms_left;
    logic [15:0] pre;
    logic        need2;
    logic        need5;
    line_t       line;
    logic [4:0]  idx;
    logic        discard;
  } top_st_t;
endpackage

// file: core/ean13_addenda_filter_formatter.sv
// EAN-13 add-on filter, book/serial formatter and output FIFO
// Function
// R1 - Prefix 2 or 977: need 2-digit add-on
// R2 - Prefix 290 setting overrides prefix 2
// R3 - Prefixes 290/978/979: need 5-digit add-on
// R4 - Prefix 378/379: none, 5, 2, either
// R5 - Prefix 414/419: independent four-way setting
// R6 - Prefix 434/439: independent four-way setting
// R7 - Met requirement outputs symbol plus add-on
// R8 - Missing add-on at timeout discards symbol
// R9 - No prefix rule: general setting decides
// R10 - Reset clears all prefix requirements
// R11 - Timeout 0 to 65535 ms, default 100
// R12 - One timeout for every add-on search
// R13 - Optional space before add-on, default off
// R14 - Redundancy count 0 to 10, default 0
// R15 - Book symbols translate to ISBN form
// R16 - ISBN output optionally in 13 digits
// R17 - Book reformat drops 978/979 prefix
// R18 - Prefix 977 translates to 8-digit ISSN
// R19 - ISSN reformat inserts hyphens
// R20 - General setting: accept only with add-on
// R21 - Timeout counted down by millisecond tick
`timescale 1ns/10ps
`default_nettype none
`include "ean13_defs.svh"

module ean13_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } fifo_st_t;
  fifo_st_t q, d;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end

  logic [AW:0] fill;
  assign fill        = q.wp - q.rp;
  assign in_ready_o  = fill != (AW+1)'(DEPTH);
  assign out_valid_o = fill != '0;
  assign out_data_o  = q.mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid_i && in_ready_o) begin
      d.mem[q.wp[AW-1:0]] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (out_valid_o && out_ready_i) begin
      d.rp = q.rp + 1'b1;
    end
    if (!rst_n_i) begin
      d.wp = '0;
      d.rp = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end
endmodule // ean13_fifo

module ean13_addenda_filter_formatter
  import ean13_pkg::*;
#(
  parameter int unsigned MS_CYCLES  = `MS_CYCLES,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Configuration, captured on cfg_load_i
  input  wire logic        cfg_load_i,
  input  wire logic        req2_i,
  input  wire logic        req290_i,
  input  wire logic        req977_i,
  input  wire logic        req978_i,
  input  wire logic        req979_i,
  input  wire logic [1:0]  mode378_i,
  input  wire logic [1:0]  mode414_i,
  input  wire logic [1:0]  mode434_i,
  input  wire logic        addon_req_i,
  input  wire logic [15:0] timeout_ms_i,
  input  wire logic        sep_en_i,
  input  wire logic [3:0]  redund_i,
  input  wire logic        isbn_en_i,
  input  wire logic        isbn13_i,
  input  wire logic        isbn_refmt_i,
  input  wire logic        issn_en_i,
  input  wire logic        issn_refmt_i,
  // Symbol decoder
  input  wire logic        sym_valid_i,
  input  wire logic [51:0] sym_digits_i,
  output logic             sym_ready_o,
  input  wire logic        addon_valid_i,
  input  wire logic        addon_five_i,
  input  wire logic [19:0] addon_digits_i,
  // Host character stream
  output logic             out_valid_o,
  output logic [7:0]       out_char_o,
  output logic             out_last_o,
  input  wire logic        out_ready_i,
  // Status
  output logic             busy_o,
  output logic             discard_o
);
  if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end

  top_st_t q, d;

  function automatic logic [3:0] dg(input logic [51:0] s, input int k);
    return s[51-4*k -: 4];
  endfunction

  function automatic logic [1:0] mode_bits(input amode_t m);
    return {m == M_TWO || m == M_ANY, m == M_FIVE || m == M_ANY};
  endfunction

  // Returns {need2, need5}
  function automatic logic [1:0] need_of(input logic [51:0] s, input cfg_t c);
    logic [11:0] p;
    logic [1:0]  n;
    p = s[51:40];
    n = 2'b00;
    // R2 prefix 290 precedence
    if (p == `PFX_290 && c.req290) n = 2'b01;
    // R1 two-digit prefixes
    else if (dg(s, 0) == `LEAD_TWO && c.req2) n = 2'b10;
    if (p == `PFX_977 && c.req977) n = 2'b10;
    // R3 five-digit prefixes
    if ((p == `PFX_978 && c.req978) || (p == `PFX_979 && c.req979)) n = 2'b01;
    // R4 prefix 378/379 mode
    if (p == `PFX_378 || p == `PFX_379) n = mode_bits(c.mode378);
    // R5 prefix 414/419 mode
    if (p == `PFX_414 || p == `PFX_419) n = mode_bits(c.mode414);
    // R6 prefix 434/439 mode
    if (p == `PFX_434 || p == `PFX_439) n = mode_bits(c.mode434);
    // R9 R20 general setting fallback
    if (n == 2'b00 && c.addon_req) n = 2'b11;
    return n;
  endfunction

  // Mod-11 check char, weights falling to 2 at the last digit
  function automatic logic [7:0] chk11(input logic [51:0] s, input int lo, input int hi);
    int sum;
    int c;
    sum = 0;
    for (int k = 0; k < 13; k++) begin
      if (k >= lo && k <= hi) sum += int'(dg(s, k)) * (hi - k + 2);
    end
    c = (11 - (sum % 11)) % 11;
    return (c == 10) ? `ASC_X : {`ASC_ZERO_HI, 4'(c)};
  endfunction

  function automatic line_t build(input logic [51:0] s, input logic [19:0] a,
                                  input logic ha, input logic a5, input cfg_t c);
    line_t r;
    int    n;
    logic  book;
    logic  ser;
    r = '0;
    n = 0;
    book = c.isbn_en && (s[51:40] == `PFX_978 || s[51:40] == `PFX_979);
    ser  = c.issn_en && s[51:40] == `PFX_977;
    // R18 serial-number translation
    if (ser) begin
      for (int k = 3; k <= 9; k++) begin
        r.ch[n] = {`ASC_ZERO_HI, dg(s, k)};
        n++;
        // R19 hyphenated serial number
        if (c.issn_refmt && k == 6) begin
          r.ch[n] = `ASC_HYPHEN;
          n++;
        end
      end
      if (c.issn_refmt) begin
        r.ch[n] = `ASC_HYPHEN;
        n++;
      end
      r.ch[n] = chk11(s, 3, 9);
      n++;
    end else if (book && !c.isbn13) begin
      // R15 ten-digit book number
      for (int k = 3; k <= 11; k++) begin
        r.ch[n] = {`ASC_ZERO_HI, dg(s, k)};
        n++;
      end
      r.ch[n] = chk11(s, 3, 11);
      n++;
    end else begin
      // R16 R17 13-digit form, prefix optionally dropped
      for (int k = (book && c.isbn_refmt) ? 3 : 0; k <= 12; k++) begin
        r.ch[n] = {`ASC_ZERO_HI, dg(s, k)};
        n++;
      end
    end
    // R7 add-on joined to main symbol
    if (ha) begin
      // R13 optional separator
      if (c.sep) begin
        r.ch[n] = `ASC_SPACE;
        n++;
      end
      for (int k = 0; k < 5; k++) begin
        if (k < 2 || a5) begin
          r.ch[n] = {`ASC_ZERO_HI, a[19-4*k -: 4]};
          n++;
        end
      end
    end
    r.len = 5'(n);
    return r;
  endfunction

  logic [3:0] votes_n;
  logic       pass;
  logic [1:0] need;
  logic       take_sym;
  logic       addon_ok;
  logic       f_valid;
  logic       f_ready;
  logic       f_last;
  logic [8:0] f_out;

  // R14 consecutive identical decodes
  assign votes_n  = (sym_digits_i == q.last) ?
                    ((q.votes == `RED_MAX) ? q.votes : q.votes + 4'h1) : 4'h0;
  assign pass     = votes_n >= q.cfg.redund;
  assign need     = need_of(sym_digits_i, q.cfg);
  assign take_sym = q.st == S_IDLE && sym_valid_i;
  assign addon_ok = addon_valid_i && (addon_five_i ? q.need5 : q.need2);
  assign f_valid  = q.st == S_EMIT;
  assign f_last   = q.idx == q.line.len - 5'd1;

  always_comb begin
    d = q;
    d.discard = 1'b0;
    if (cfg_load_i) begin
      d.cfg = '{req2_i, req290_i, req977_i, req978_i, req979_i, amode_t'(mode378_i),
                amode_t'(mode414_i), amode_t'(mode434_i), addon_req_i, timeout_ms_i,
                sep_en_i, (redund_i > `RED_MAX) ? `RED_MAX : redund_i, isbn_en_i,
                isbn13_i, isbn_refmt_i, issn_en_i, issn_refmt_i};
    end
    case (q.st)
      S_IDLE: begin
        if (take_sym) begin
          d.last  = sym_digits_i;
          d.votes = pass ? 4'h0 : votes_n;
          if (pass) begin
            d.sym   = sym_digits_i;
            d.need2 = need[1];
            d.need5 = need[0];
            d.idx   = '0;
            if (need == 2'b00) begin
              d.line = build(sym_digits_i, '0, 1'b0, 1'b0, q.cfg);
              d.st   = S_EMIT;
            end else begin
              // R12 R21 one timeout, started at decode
              d.ms_left = q.cfg.tmo;
              d.pre     = '0;
              d.st      = S_WAIT;
            end
          end
        end
      end
      S_WAIT: begin
        if (addon_ok) begin
          d.line = build(q.sym, addon_digits_i, 1'b1, addon_five_i, q.cfg);
          d.st   = S_EMIT;
        end else if (q.ms_left == '0) begin
          // R8 timeout discard
          d.discard = 1'b1;
          d.st      = S_IDLE;
        end else if (q.pre == 16'(MS_CYCLES - 1)) begin
          // R21 millisecond tick
          d.pre     = '0;
          d.ms_left = q.ms_left - 16'h0001;
        end else begin
          d.pre = q.pre + 16'h0001;
        end
      end
      S_EMIT: begin
        if (f_ready) begin
          d.idx = q.idx + 5'd1;
          if (f_last) d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
    // R10 R11 defaults restored
    if (!rst_n_i) begin
      d     = '0;
      d.cfg.tmo    = `TMO_DEF;
      d.cfg.redund = `RED_DEF;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  ean13_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (f_valid),
    .in_data_i   ({f_last, q.line.ch[q.idx]}),
    .in_ready_o  (f_ready),
    .out_valid_o (out_valid_o),
    .out_data_o  (f_out),
    .out_ready_i (out_ready_i)
  );

  assign out_char_o  = f_out[7:0];
  assign out_last_o  = f_out[8];
  assign sym_ready_o = q.st == S_IDLE;
  assign busy_o      = q.st != S_IDLE;
  assign discard_o   = q.discard;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence accept_seq;
    take_sym && pass;
  endsequence
  sequence wait_expire_seq;
    q.st == S_WAIT && q.ms_left == '0 && !addon_ok;
  endsequence

  chk_prefix290_wins: assert property (accept_seq ##0 sym_digits_i[51:40] == `PFX_290 // R2
    ##0 q.cfg.req290 && q.cfg.req2 |=> q.st == S_WAIT && q.need5 && !q.need2)
    else $error("prefix 290 did not override prefix 2");
  chk_two_digit_need: assert property (accept_seq ##0 sym_digits_i[51:40] == `PFX_977 // R1
    ##0 q.cfg.req977 |=> q.st == S_WAIT && q.need2 && !q.need5)
    else $error("977 symbol not waiting for 2-digit add-on");
  chk_five_digit_need: assert property (accept_seq ##0 sym_digits_i[51:40] == `PFX_978 // R3
    ##0 q.cfg.req978 |=> q.st == S_WAIT && q.need5 && !q.need2)
    else $error("978 symbol not waiting for 5-digit add-on");
  chk_mode_either: assert property (accept_seq ##0 sym_digits_i[51:40] == `PFX_434 // R6
    ##0 q.cfg.mode434 == M_ANY |=> q.need2 && q.need5)
    else $error("either-add-on mode not applied");
  chk_timeout_discard: assert property (wait_expire_seq |=> q.st == S_IDLE && discard_o) // R8
    else $error("expired search did not discard");
  chk_concat_tail: assert property (q.st == S_WAIT && addon_ok |=> q.st == S_EMIT // R7
    && q.line.ch[q.line.len - 5'd1][3:0] == $past(addon_five_i ?
       addon_digits_i[3:0] : addon_digits_i[15:12]))
    else $error("add-on not at end of joined message");
  chk_ms_countdown: assert property (q.st == S_WAIT && !addon_ok && q.ms_left != '0 // R21
    && q.pre == 16'(MS_CYCLES - 1) |=> q.ms_left == $past(q.ms_left) - 16'h0001)
    else $error("millisecond countdown wrong");
  chk_reset_defaults: assert property (disable iff (1'b0) !rst_n_i |=> q.cfg.tmo == `TMO_DEF // R10
    && !q.cfg.req2 && !q.cfg.req290 && q.cfg.mode378 == M_NONE && q.st == S_IDLE)
    else $error("defaults not restored by reset");
  chk_redund_gate: assert property (take_sym && !pass |=> q.st == S_IDLE) // R14
    else $error("symbol passed before enough identical reads");
  chk_no_rule_emit: assert property (accept_seq ##0 need == 2'b00 |=> q.st == S_EMIT) // R9
    else $error("unrestricted symbol not output");
endmodule // ean13_addenda_filter_formatter

`default_nettype wire

// file: dv/dec_host.sv
// Decoder source and host sink model for the add-on filter bench
`timescale 1ns/10ps
`default_nettype none
module dec_host (
  input  wire logic        clk_i,
  // Decoder side
  output logic             sym_valid_o,
  output logic [51:0]      sym_digits_o,
  input  wire logic        sym_ready_i,
  output logic             addon_valid_o,
  output logic             addon_five_o,
  output logic [19:0]      addon_digits_o,
  // Host side
  input  wire logic        out_valid_i,
  input  wire logic [7:0]  out_char_i,
  input  wire logic        out_last_i,
  output logic             out_ready_o,
  input  wire logic        discard_i
);
  logic [7:0] got[$];
  int         cyc, hold, t_take, t_disc, discs, lasts;
  initial begin
    sym_valid_o = 1'b0;
    sym_digits_o = '0;
    addon_valid_o = 1'b0;
    addon_five_o = 1'b0;
    addon_digits_o = '0;
    out_ready_o = 1'b0;
  end
  // Host stalls one cycle in four, fully while hold runs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (hold > 0) hold <= hold - 1;
    out_ready_o <= (hold == 0) && (cyc % 4 != 3);
    if (out_valid_i && out_ready_o) got.push_back(out_char_i);
    if (out_valid_i && out_ready_o && out_last_i) lasts++;
    if (discard_i) discs++;
    if (discard_i) t_disc = cyc;
  end
  // Released digit buses carry the inverse; addon_five_o keeps its stale value
  task automatic send(input logic [51:0] s, input logic [19:0] a, input logic five, has);
    @(posedge clk_i);
    sym_valid_o <= 1'b1;
    sym_digits_o <= s;
    @(negedge clk_i);
    while (!sym_ready_i) @(negedge clk_i);
    @(posedge clk_i);
    t_take = cyc;
    sym_valid_o <= 1'b0;
    sym_digits_o <= ~s;
    if (has) begin
      repeat (2) @(posedge clk_i);
      addon_valid_o <= 1'b1;
      addon_five_o <= five;
      addon_digits_o <= a;
      @(posedge clk_i);
      addon_valid_o <= 1'b0;
      addon_digits_o <= ~a;
    end
  endtask
endmodule // dec_host
`default_nettype wire

// file: dv/ean13_addenda_filter_formatter_bench.sv
// Self-checking bench for the EAN-13 add-on filter and formatter
`timescale 1ns/10ps
`default_nettype none
module ean13_addenda_filter_formatter_bench;
  localparam int MS = 4;
  logic        clk_i, rst_n_i, cfg_load_i, req2_i, req290_i, req977_i, req978_i, req979_i;
  logic        addon_req_i, sep_en_i, isbn_en_i, isbn13_i, isbn_refmt_i, issn_en_i;
  logic        issn_refmt_i, sym_valid_i, sym_ready_o, addon_valid_i, addon_five_i;
  logic        out_valid_o, out_last_o, out_ready_i, busy_o, discard_o;
  logic [1:0]  mode378_i, mode414_i, mode434_i;
  logic [15:0] timeout_ms_i;
  logic [3:0]  redund_i;
  logic [51:0] sym_digits_i, last_s, rs;
  logic [19:0] addon_digits_i;
  logic [7:0]  out_char_o;
  logic [7:0]  exp_q[$];
  logic [11:0] pf[3] = '{12'h378, 12'h419, 12'h434};
  int          err_total, samples_checked, votes, exp_disc, seed;

  ean13_addenda_filter_formatter #(.MS_CYCLES(MS), .FIFO_DEPTH(16)) u_ean13_addenda_filter_formatter (
    .clk_i, .rst_n_i, .cfg_load_i, .req2_i, .req290_i, .req977_i, .req978_i, .req979_i,
    .mode378_i, .mode414_i, .mode434_i, .addon_req_i, .timeout_ms_i, .sep_en_i, .redund_i,
    .isbn_en_i, .isbn13_i, .isbn_refmt_i, .issn_en_i, .issn_refmt_i, .sym_valid_i,
    .sym_digits_i, .sym_ready_o, .addon_valid_i, .addon_five_i, .addon_digits_i,
    .out_valid_o, .out_char_o, .out_last_o, .out_ready_i, .busy_o, .discard_o);

  dec_host u_dec_host (.clk_i(clk_i), .sym_valid_o(sym_valid_i), .sym_digits_o(sym_digits_i),
    .sym_ready_i(sym_ready_o), .addon_valid_o(addon_valid_i), .addon_five_o(addon_five_i),
    .addon_digits_o(addon_digits_i), .out_valid_i(out_valid_o), .out_char_i(out_char_o),
    .out_last_i(out_last_o), .out_ready_o(out_ready_i), .discard_i(discard_o));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [7:0] asc(input int v);
    return 8'h30 + 8'(v);
  endfunction

  function automatic void model(input logic [51:0] s, input logic [19:0] a, input logic five, has);
    int d[13];
    int p, need, sum, v, ck;
    exp_q.delete();
    exp_disc = 0;
    need = 0;
    sum = 0;
    ck = 0;
    v = (redund_i > 4'hA) ? 10 : int'(redund_i);
    // Repeats of the previous read are counted; a fresh symbol starts at zero
    votes = (s === last_s) ? votes + 1 : 0;
    last_s = s;
    if (votes < v) return;
    votes = 0;
    foreach (d[i]) d[i] = int'(s[51 - 4 * i -: 4]);
    p = d[0] * 100 + d[1] * 10 + d[2];
    if (p inside {378, 379}) need = int'(mode378_i);
    else if (p inside {414, 419}) need = int'(mode414_i);
    else if (p inside {434, 439}) need = int'(mode434_i);
    else if (p == 977 && req977_i) need = 2;
    else if ((p == 290 && req290_i) || (p == 978 && req978_i) || (p == 979 && req979_i)) need = 1;
    else if (d[0] == 2 && req2_i) need = 2;
    if (need == 0 && addon_req_i) need = 3;
    if (need != 0 && !(has && (five ? need != 2 : need != 1))) begin
      exp_disc = 1;
      return;
    end
    if (p == 977 && issn_en_i) begin
      ck = 1;
      for (int i = 3; i < 10; i++) begin
        if (issn_refmt_i && i == 7) exp_q.push_back(8'h2D);
        exp_q.push_back(asc(d[i]));
        sum += d[i] * (11 - i);
      end
      if (issn_refmt_i) exp_q.push_back(8'h2D);
    end else if ((p == 978 || p == 979) && isbn_en_i) begin
      ck = int'(!isbn13_i);
      for (int i = 3 * int'(!isbn13_i || isbn_refmt_i); i < (isbn13_i ? 13 : 12); i++) begin
        exp_q.push_back(asc(d[i]));
        sum += d[i] * (13 - i);
      end
    end else foreach (d[i]) exp_q.push_back(asc(d[i]));
    sum = (11 - sum % 11) % 11;
    if (ck != 0) exp_q.push_back(sum == 10 ? 8'h58 : asc(sum));
    if (need == 0) return;
    if (sep_en_i) exp_q.push_back(8'h20);
    for (int k = 0; k < (five ? 5 : 2); k++) exp_q.push_back(asc(int'(a[19 - 4 * k -: 4])));
  endfunction

  task automatic run(input logic [51:0] s, input logic [19:0] a, input logic five, has);
    int d0, l0, dt;
    logic bad;
    model(s, a, five, has);
    d0 = u_dec_host.discs;
    l0 = u_dec_host.lasts;
    u_dec_host.got.delete();
    u_dec_host.send(s, a, five, has);
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk_i);
      if (!busy_o && sym_ready_o && !out_valid_o) break;
    end
    repeat (3) @(negedge clk_i);
    dt = u_dec_host.t_disc - u_dec_host.t_take;
    bad = (u_dec_host.got.size() != exp_q.size()) || (u_dec_host.discs - d0 != exp_disc);
    if (u_dec_host.lasts - l0 != int'(exp_q.size() > 0)) bad = 1'b1;
    if (exp_disc != 0 && (dt < timeout_ms_i * MS || dt > timeout_ms_i * MS + 3)) bad = 1'b1;
    foreach (exp_q[i]) if (i < u_dec_host.got.size() && u_dec_host.got[i] !== exp_q[i]) bad = 1'b1;
    samples_checked++;
    if (bad) begin
      err_total++;
      $display("unexpected output at %0t for %h: got %0h chars %0h drops, want %0h chars %0h drops",
               $time, s, u_dec_host.got.size(), u_dec_host.discs - d0, exp_q.size(), exp_disc);
    end
  endtask

  task automatic load();
    cfg_load_i <= 1'b1;
    @(posedge clk_i);
    cfg_load_i <= 1'b0;
  endtask

  task automatic clear();
    @(posedge clk_i);
    {req2_i, req290_i, req977_i, req978_i, req979_i, mode378_i, mode414_i, mode434_i, addon_req_i,
     sep_en_i, isbn_en_i, isbn13_i, isbn_refmt_i, issn_en_i, issn_refmt_i} <= '0;
    @(posedge clk_i);
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    results();
  end

  initial begin
    seed = 32'hc942;
    last_s = '0;
    {req2_i, req290_i, req977_i, req978_i, req979_i, mode378_i, mode414_i, mode434_i, addon_req_i,
     sep_en_i, isbn_en_i, isbn13_i, isbn_refmt_i, issn_en_i, issn_refmt_i} = '0;
    timeout_ms_i = 16'h0064;
    redund_i = 4'h0;
    cfg_load_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    samples_checked++;
    if ({sym_ready_o, busy_o, out_valid_o, discard_o} !== 4'h8) begin
      err_total++;
      $display("unexpected idle flags at %0t: %h, want %h", $time,
               {sym_ready_o, busy_o, out_valid_o, discard_o}, 4'h8);
    end
    run(52'h2012_3456_7890_5, 20'h1_2000, 1'b0, 1'b1);
    @(posedge clk_i);
    req2_i <= 1'b1;
    req977_i <= 1'b1;
    sep_en_i <= 1'b1;
    timeout_ms_i <= 16'h0002;
    load();
    u_dec_host.hold = 40;
    run(52'h2012_3456_7890_5, 20'h3_4000, 1'b0, 1'b1);
    run(52'h2012_3456_7890_5, 20'h0_0000, 1'b0, 1'b0);
    run(52'h2012_3456_7890_5, 20'h1_2345, 1'b1, 1'b1);
    run(52'h9771_2345_6789_8, 20'h5_6000, 1'b0, 1'b1);
    @(posedge clk_i);
    req290_i <= 1'b1;
    req978_i <= 1'b1;
    req979_i <= 1'b1;
    load();
    u_dec_host.hold = 40;
    run(52'h2901_2345_6789_3, 20'h1_2345, 1'b1, 1'b1);
    run(52'h2901_2345_6789_3, 20'h1_2000, 1'b0, 1'b1);
    run(52'h9780_3064_0615_7, 20'h5_4321, 1'b1, 1'b1);
    run(52'h9791_2345_6789_6, 20'h0_0000, 1'b0, 1'b0);
    for (int j = 0; j < 3; j++) for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      {mode378_i, mode414_i, mode434_i} <= 6'(m % 4) << (4 - 2 * j);
      load();
      run({pf[j], 40'h12_3456_7890}, 20'h2_4680, m[2], 1'b1);
    end
    clear();
    addon_req_i <= 1'b1;
    timeout_ms_i <= 16'h0000;
    load();
    run(52'h5012_3456_7890_0, 20'h0_0000, 1'b0, 1'b0);
    @(posedge clk_i);
    timeout_ms_i <= 16'h0001;
    load();
    run(52'h5012_3456_7890_0, 20'h7_7000, 1'b0, 1'b1);
    clear();
    for (int k = 0; k < 4; k++) begin
      // book and serial translation enabled; serial reformat set on odd passes only
      {isbn_en_i, issn_en_i, isbn13_i, isbn_refmt_i, issn_refmt_i} <= {2'b11, 2'(k), k[0]};
      load();
      run(52'h9780_3064_0615_7, 20'h0_0000, 1'b0, 1'b0);
      run(52'h9791_2345_6789_6, 20'h0_0000, 1'b0, 1'b0);
      run(52'h9770_1234_5678_7, 20'h0_0000, 1'b0, 1'b0);
      @(posedge clk_i);
    end
    clear();
    redund_i <= 4'h2;
    load();
    run(52'h4006_3813_3393_1, 20'h0_0000, 1'b0, 1'b0);
    run(52'h4006_3813_3393_1, 20'h0_0000, 1'b0, 1'b0);
    run(52'h4006_3813_3393_1, 20'h0_0000, 1'b0, 1'b0);
    run(52'h4006_3813_3394_8, 20'h0_0000, 1'b0, 1'b0);
    @(posedge clk_i);
    redund_i <= 4'h0;
    for (int r = 0; r < 8; r++) begin
      for (int k = 0; k < 13; k++) rs = {rs[47:0], 4'($unsigned($random(seed)) % 10)};
      @(posedge clk_i);
      sep_en_i <= 1'($random(seed));
      load();
      run(rs, 20'h9_8765, 1'($random(seed)), 1'b1);
    end
    results();
  end
endmodule // ean13_addenda_filter_formatter_bench
`default_nettype wire
